// ===== design/program_fetch_ext_memory_bus.v
// Program fetch steering and multiplexed external memory bus
`timescale 1ns/100ps
`include "ext_bus_defs.vh"
module program_fetch_ext_memory_bus #(
    parameter MEM_KB = 32
)(
    input wire mclk,
    input wire rst,
    input wire clkEn,
    input wire extFetchSelectPin,
    input wire progMode,
    input wire bootRomEnable,
    input wire [7:0] hwConfigByteOne,
    input wire cfgWrite,
    input wire [7:0] cfgWriteData,
    input wire [15:0] partitionLimit,
    input wire reqValid,
    input wire [1:0] reqKind,
    input wire reqShort,
    input wire [15:0] reqAddr,
    input wire [7:0] reqWdata,
    input wire [7:0] intRdata,
    input wire [7:0] bootRdata,
    input wire [7:0] sfrAddr,
    input wire sfrWrite,
    input wire [7:0] sfrWdata,
    input wire [7:0] lowPortIn,
    input wire [7:0] lowPortGpio,
    input wire [7:0] highPortGpio,
    input wire [7:0] lowPortGpioOe,
    output reg [15:0] pcStart,
    output reg [7:0] sfrRdata,
    output reg reqBusy,
    output reg respValid,
    output reg [7:0] respData,
    output reg [1:0] respSource,
    output reg [7:0] lowPortOut,
    output reg [7:0] lowPortOeN,
    output reg [7:0] highPortOut,
    output reg addrLatchStrobe,
    output reg programReadStrobeN,
    output reg dataReadStrobeN,
    output reg dataWriteStrobeN,
    output reg strobePinsDedicated
);
// Sized wide first so the cut to 16 bits is deliberate
localparam [31:0] INT_TOP_WIDE = MEM_KB * 1024 - 1;
localparam [15:0] INT_TOP = INT_TOP_WIDE[15:0];
localparam [4:0] ST_IDLE = 5'h01;
localparam [4:0] ST_ADDR = 5'h02;
localparam [4:0] ST_STROBE = 5'h04;
localparam [4:0] ST_HOLD = 5'h08;
localparam [4:0] ST_DONE = 5'h10;

reg [7:0] extDataPage;
reg [7:0] hwCfg;
reg allExternal;
reg resetSeen;
reg [4:0] state;
reg [4:0] next_state;
reg [2:0] cnt;
reg [1:0] kind;
reg [1:0] src;
reg shortAddr;
reg [15:0] addr;
reg [7:0] wdata;
reg busOn;
reg [1:0] next_src;
reg [15:0] intLimit;

// Config changes only in programming mode; default is general I/O
always @(posedge mclk)
begin
    if (rst)
        hwCfg <= `CFG_RESET;
    else if (clkEn && cfgWrite && progMode)
        hwCfg <= cfgWriteData;
end

always @*
begin
    busOn = ~hwCfg[`CFG_P2_BIT] & ~hwCfg[`CFG_P0_BIT];
end

// Strap caught on the first enabled edge after reset release
always @(posedge mclk)
begin
    if (rst)
    begin
        allExternal <= 1'b0;
        resetSeen <= 1'b0;
        pcStart <= `RESET_PC;
    end
    else if (clkEn && !resetSeen)
    begin
        allExternal <= ~extFetchSelectPin;
        resetSeen <= 1'b1;
    end
end

always @(posedge mclk)
begin
    if (rst)
        extDataPage <= `PAGE_REG_RESET;
    else if (clkEn && sfrWrite && sfrAddr == `PAGE_REG_ADDR)
        extDataPage <= sfrWdata;
end

always @(posedge mclk)
begin
    if (rst)
        sfrRdata <= 8'h00;
    else if (clkEn)
        sfrRdata <= (sfrAddr == `PAGE_REG_ADDR) ? extDataPage : 8'h00;
end

// Source selection for a new request
always @*
begin
    intLimit = (partitionLimit < INT_TOP) ? partitionLimit
        : INT_TOP;
    next_src = `SRC_EXTERNAL;
    // Data moves use the external strobes whenever the bus is on
    if (reqKind != `KIND_FETCH)
        next_src = busOn ? `SRC_EXTERNAL : `SRC_INTERNAL;
    else if (bootRomEnable && !progMode && reqAddr >= `BOOT_USER_BASE)
        next_src = `SRC_BOOT;
    else if (progMode && reqAddr <= `BOOT_PROG_TOP)
        next_src = `SRC_BOOT;
    else if (allExternal)
        next_src = `SRC_EXTERNAL;
    else if (reqAddr <= intLimit)
        next_src = `SRC_INTERNAL;
    if (next_src == `SRC_EXTERNAL && reqKind == `KIND_FETCH && !busOn
        && !allExternal)
        next_src = `SRC_INTERNAL;
end

always @*
begin
    next_state = state;
    case (state)
        ST_IDLE:
            if (reqValid)
                next_state = ST_ADDR;
        ST_ADDR:
            if (cnt == 3'h0)
                next_state = ST_STROBE;
        ST_STROBE:
            if (cnt == 3'h0)
                next_state = ST_HOLD;
        ST_HOLD:
            next_state = ST_DONE;
        ST_DONE:
            next_state = ST_IDLE;
        default:
            next_state = ST_IDLE;
    endcase
end

always @(posedge mclk)
begin
    if (rst)
    begin
        state <= ST_IDLE;
        cnt <= 3'h0;
        kind <= `KIND_FETCH;
        src <= `SRC_INTERNAL;
        shortAddr <= 1'b0;
        addr <= 16'h0000;
        wdata <= 8'h00;
        reqBusy <= 1'b0;
        respValid <= 1'b0;
        respData <= 8'h00;
        respSource <= `SRC_INTERNAL;
        lowPortOut <= 8'h00;
        lowPortOeN <= 8'hFF;
        highPortOut <= 8'h00;
        addrLatchStrobe <= 1'b0;
        programReadStrobeN <= 1'b1;
        dataReadStrobeN <= 1'b1;
        dataWriteStrobeN <= 1'b1;
        strobePinsDedicated <= 1'b0;
    end
    else if (clkEn)
    begin
        state <= next_state;
        respValid <= 1'b0;
        strobePinsDedicated <= busOn;
        if (!busOn)
        begin
            // Ports stay general I/O whatever the core attempts
            lowPortOut <= lowPortGpio;
            lowPortOeN <= ~lowPortGpioOe;
            highPortOut <= highPortGpio;
            addrLatchStrobe <= 1'b0;
        end
        case (state)
            ST_IDLE:
            begin
                if (reqValid)
                begin
                    kind <= reqKind;
                    src <= next_src;
                    shortAddr <= reqShort;
                    addr <= reqAddr;
                    wdata <= reqWdata;
                    reqBusy <= 1'b1;
                    cnt <= `ADDR_CYCLES - 3'h1;
                    if (busOn)
                    begin
                        addrLatchStrobe <= 1'b1;
                        lowPortOeN <= 8'h00;
                        lowPortOut <= reqAddr[7:0];
                        highPortOut <= (reqKind != `KIND_FETCH && reqShort)
                            ? extDataPage : reqAddr[15:8];
                    end
                end
            end
            ST_ADDR:
            begin
                cnt <= cnt - 3'h1;
                if (cnt == 3'h0)
                begin
                    // Latch strobe falls on the same edge that the low port leaves the address
                    addrLatchStrobe <= 1'b0;
                    cnt <= `STROBE_CYCLES - 3'h1;
                    if (busOn && src == `SRC_EXTERNAL)
                    begin
                        if (kind == `KIND_WRITE)
                        begin
                            lowPortOut <= wdata;
                            dataWriteStrobeN <= 1'b0;
                        end
                        else
                        begin
                            lowPortOeN <= 8'hFF;
                            if (kind == `KIND_FETCH)
                                programReadStrobeN <= 1'b0;
                            else
                                dataReadStrobeN <= 1'b0;
                        end
                    end
                    else if (busOn)
                        lowPortOut <= 8'h00;
                end
            end
            ST_STROBE:
            begin
                cnt <= cnt - 3'h1;
                if (cnt == 3'h0)
                begin
                    if (src == `SRC_EXTERNAL && busOn)
                        respData <= lowPortIn;
                    else if (src == `SRC_BOOT)
                        respData <= bootRdata;
                    else
                        respData <= intRdata;
                    programReadStrobeN <= 1'b1;
                    dataReadStrobeN <= 1'b1;
                    dataWriteStrobeN <= 1'b1;
                end
            end
            ST_HOLD:
            begin
                // Write data stays past the strobe release, until the next request drives an address
                if (busOn && kind != `KIND_WRITE)
                    lowPortOeN <= 8'h00;
                if (busOn && kind != `KIND_WRITE)
                    lowPortOut <= 8'h00;
            end
            ST_DONE:
            begin
                respValid <= 1'b1;
                respSource <= src;
                reqBusy <= 1'b0;
            end
            default:
            begin
                reqBusy <= 1'b0;
            end
        endcase
    end
end
endmodule // program_fetch_ext_memory_bus

// ===== design/ext_bus_defs.vh
// Constants for the program fetch and external memory bus block
`ifndef EXT_BUS_DEFS_VH
`define EXT_BUS_DEFS_VH
`define RESET_PC 16'h0000
`define BOOT_USER_BASE 16'hF800
`define BOOT_PROG_TOP 16'h07FF
`define PAGE_REG_ADDR 8'h92
`define PAGE_REG_RESET 8'h00
`define CFG_P2_BIT 0
`define CFG_P0_BIT 1
`define CFG_RESET 8'hFF
`define SRC_INTERNAL 2'h0
`define SRC_BOOT 2'h1
`define SRC_EXTERNAL 2'h2
`define KIND_FETCH 2'h0
`define KIND_READ 2'h1
`define KIND_WRITE 2'h2
`define ADDR_CYCLES 3'h2
`define STROBE_CYCLES 3'h3
`endif

// ===== verification/ext_bus_monitor.sv
// Checker of the external bus timing
`timescale 1ns/100ps
module ext_bus_monitor (
    input wire mclk,
    input wire rst,
    input wire [15:0] pcStart,
    input wire reqBusy,
    input wire respValid,
    input wire [7:0] lowPortOut,
    input wire [7:0] lowPortOeN,
    input wire addrLatchStrobe,
    input wire programReadStrobeN,
    input wire dataReadStrobeN,
    input wire dataWriteStrobeN
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    pc_zero_a: assert property (pcStart == 16'h0000)
        else $error("start address");
    ale_valid_a: assert property (
        addrLatchStrobe && $past(addrLatchStrobe)
        |-> $stable(lowPortOut)) else $error("address moved");
    ale_len_a: assert property ($rose(addrLatchStrobe) |->
        addrLatchStrobe[*2] ##1 !addrLatchStrobe) else $error("latch width");
    strobe_len_a: assert property ($fell(programReadStrobeN) |->
        !programReadStrobeN[*3] ##1 programReadStrobeN) else $error("strobe");
    strobe_one_a: assert property (!programReadStrobeN |->
        dataReadStrobeN && dataWriteStrobeN) else $error("two strobes");
    int_zero_a: assert property ($fell(addrLatchStrobe) &&
        programReadStrobeN && dataReadStrobeN && dataWriteStrobeN
        |-> lowPortOut == 8'h00) else $error("internal data shown");
    wr_hold_a: assert property ($rose(dataWriteStrobeN) |->
        $stable(lowPortOut) && $past(lowPortOut, 3) == lowPortOut
        && lowPortOeN == 8'h00) else $error("write data");
    resp_time_a: assert property ($rose(reqBusy) |->
        ##[6:8] respValid ##1 !respValid) else $error("answer late");
    busy_span_a: assert property ($rose(reqBusy) |-> reqBusy[*6])
        else $error("busy short");
    cover property ($fell(dataWriteStrobeN));
    cover property ($fell(dataReadStrobeN));
    cover property ($fell(programReadStrobeN));
endmodule // ext_bus_monitor
bind program_fetch_ext_memory_bus ext_bus_monitor ext_bus_monitor_i (.*);

// ===== verification/ext_memory_model.sv
// External program and data memory with its address latch
`timescale 1ns/100ps
module ext_memory_model (
    input wire mclk,
    input wire slow,
    input wire [7:0] lowPortOut,
    input wire [7:0] highPortOut,
    input wire addrLatchStrobe,
    input wire programReadStrobeN,
    input wire dataReadStrobeN,
    input wire dataWriteStrobeN,
    output logic [7:0] lowPortIn = 8'h00,
    output logic [15:0] lastAddr = 16'h0000
);
    // Both reads share one memory through an AND gate
    wire readN = programReadStrobeN & dataReadStrobeN;
    logic [7:0] mem [int];
    logic prevWr = 1'h1;
    int lowCycles = 0;
    always @(posedge mclk)
    begin
        if (addrLatchStrobe)
            lastAddr <= {highPortOut, lowPortOut};
        if (!prevWr && dataWriteStrobeN)
            mem[lastAddr] = lowPortOut;
        // Slow answer still lands before the strobe ends
        if (!readN && (!slow || lowCycles > 0))
            lowPortIn <= mem.exists(lastAddr) ? mem[lastAddr]
                : lastAddr[7:0] ^ lastAddr[15:8];
        else
            lowPortIn <= ~lowPortIn;
        lowCycles <= readN ? 0 : lowCycles + 1;
        prevWr <= dataWriteStrobeN;
    end
endmodule // ext_memory_model

// ===== verification/program_fetch_ext_memory_bus_tb.sv
// Bench for fetch steering and the external bus
`timescale 1ns/100ps
module program_fetch_ext_memory_bus_tb;
    logic mclk = '0, rst = 1'h1, extFetchSelectPin = 1'h1, slow = '0;
    logic progMode = '0, bootRomEnable = '0, cfgWrite = '0, busOn = '0;
    logic reqValid = '0, reqShort = '0, sfrWrite = '0;
    logic [1:0] reqKind = '0;
    logic [7:0] cfgWriteData = '0, reqWdata = '0, intRdata = '0, page = '0;
    logic [7:0] bootRdata = '0, sfrAddr = '0, sfrWdata = '0, lowPortGpio = '0;
    logic [7:0] highPortGpio = 8'hFF;
    logic [15:0] reqAddr = '0, partitionLimit = 16'hFFFF;
    logic [15:0] fa [4] = '{16'h7FFF, 16'h8000, 16'hF800, 16'h7C00};
    logic [7:0] cv [3] = '{8'hFE, 8'hFD, 8'hFC};
    logic [7:0] extMem [int];
    wire clkEn = 1'h1;
    wire [7:0] hwConfigByteOne = 8'hFF, lowPortGpioOe = 8'h0F;
    wire [7:0] sfrRdata, respData, lowPortOut, lowPortOeN;
    wire [7:0] highPortOut, lowPortIn;
    wire [15:0] pcStart, lastAddr;
    wire [1:0] respSource;
    wire reqBusy, respValid, addrLatchStrobe, programReadStrobeN;
    wire dataReadStrobeN, dataWriteStrobeN, strobePinsDedicated;
    int num_errors = 0, n_compared = 0, cycles = 0;
    program_fetch_ext_memory_bus program_fetch_ext_memory_bus_i (.*);
    ext_memory_model ext_memory_model_i (.*);
    initial forever #10 mclk = ~mclk;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task tally_and_finish;
        $display("compared %0d errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic sfr(input logic [7:0] a, input logic w,
        input logic [7:0] v);
        @(posedge mclk);
        sfrAddr <= a;
        sfrWrite <= w;
        sfrWdata <= v;
        @(posedge mclk);
        sfrWrite <= '0;
        if (w)
            page = v;
        repeat (2) @(posedge mclk);
        chk(sfrRdata, a == 8'h92 ? page : 8'h00);
    endtask
    task automatic acc(input logic [1:0] k, input logic s,
        input logic [15:0] a);
        logic [1:0] src;
        logic [15:0] ea;
        logic [7:0] e;
        logic [7:0] d;
        // Mode changes made just before the call settle first
        repeat (2) @(posedge mclk);
        d = $urandom;
        ea = k && s ? {page, a[7:0]} : a;
        src = k ? {busOn, 1'h0} : (progMode ? a < 16'h0800
            : bootRomEnable && a >= 16'hF800) ? 2'h1
            : !extFetchSelectPin || busOn && (a > 16'h7FFF
            || a > partitionLimit) ? 2'h2 : 2'h0;
        e = src == 2'h1 ? bootRdata : !src[1] ? intRdata
            : extMem.exists(ea) ? extMem[ea] : ea[7:0] ^ ea[15:8];
        if (k[1] && src[1])
            extMem[ea] = d;
        reqValid <= 1'h1;
        reqKind <= k;
        reqShort <= s;
        reqAddr <= a;
        reqWdata <= d;
        @(posedge mclk);
        reqValid <= '0;
        for (int n = 0; n < 12 && respValid !== 1'h1; n++)
            @(posedge mclk);
        chk(respSource, src);
        chk(respValid, 1'h1);
        chk(strobePinsDedicated, busOn);
        if (!busOn)
        begin
            chk(lowPortOut, lowPortGpio);
            chk(highPortOut, highPortGpio);
            chk(lowPortOeN, 8'(~lowPortGpioOe));
        end
        if (!k[1] && (!src[1] || busOn))
            chk(respData, e);
        if (busOn)
            chk(lastAddr, ea);
    endtask
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            num_errors++;
            tally_and_finish;
        end
    end
    initial
    begin
        void'($urandom(32'hd76d7413));
        repeat (20) @(posedge mclk);
        rst <= '0;
        intRdata <= $urandom;
        bootRdata <= $urandom;
        lowPortGpio <= $urandom;
        sfr(8'h92, '0, '0);
        acc(2'h0, '0, 16'h8000);
        @(posedge mclk);
        cfgWrite <= 1'h1;
        cfgWriteData <= 8'hFC;
        @(posedge mclk);
        cfgWrite <= '0;
        acc(2'h1, '0, 16'h3000);
        progMode <= 1'h1;
        foreach (cv[i])
        begin
            @(posedge mclk);
            cfgWrite <= 1'h1;
            cfgWriteData <= cv[i];
            @(posedge mclk);
            cfgWrite <= '0;
            busOn = cv[i][1:0] == 2'h0;
            acc(2'h1, '0, 16'($urandom));
        end
        acc(2'h0, '0, 16'h0100);
        progMode <= '0;
        for (int p = 0; p < 2; p++)
        begin
            bootRomEnable <= p[0];
            partitionLimit <= p ? 16'h7BFF : 16'hFFFF;
            foreach (fa[i])
                acc(2'h0, '0, fa[i]);
        end
        sfr(8'h92, 1'h1, 8'($urandom));
        sfr(8'h93, '0, '0);
        acc(2'h2, 1'h1, 16'h00A5);
        slow <= 1'h1;
        acc(2'h1, 1'h1, 16'h00A5);
        repeat (16)
        begin
            slow <= 1'($urandom);
            acc(2'($urandom % 3), 1'($urandom), 16'($urandom));
        end
        rst <= 1'h1;
        extFetchSelectPin <= '0;
        @(posedge mclk);
        rst <= '0;
        busOn = '0;
        page = '0;
        acc(2'h0, '0, 16'h0100);
        tally_and_finish;
    end
endmodule // program_fetch_ext_memory_bus_tb
